// file: shared/gec_defs.svh
// gesture engine configuration: register map, fields, reset values, timing
// assumes a 10 MHz core clock and i2c register access
`ifndef GEC_DEFS_SVH
`define GEC_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define GEC_OFS_SOUTH    8'hA5
`define GEC_PULSE_SETUP  8'hA6
`define GEC_OFS_WEST     8'hA7
`define GEC_OFS_EAST     8'hA9
`define GEC_PAIR_SEL     8'hAA
`define GEC_CONTROL      8'hAB
`define GEC_QUEUE_LEVEL  8'hAE
`define GEC_FIFO_NORTH   8'hFC
`define GEC_FIFO_SOUTH   8'hFD
`define GEC_FIFO_WEST    8'hFE
`define GEC_FIFO_EAST    8'hFF

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define GEC_OFS_SIGN_BIT 7
`define GEC_CTL_UNMASK   1
`define GEC_CTL_RUN      0
`define GEC_RST_BYTE     8'h00
`define GEC_FIFO_DEPTH   8'h20
`define GEC_DEV_ADDR     7'h39

// ----------------------------------------
// timing
// ----------------------------------------
`define GEC_CLK_MHZ      10
`define GEC_PLEN_US      4
`define GEC_PLEN_CYC     (`GEC_PLEN_US * `GEC_CLK_MHZ)

`endif

// file: shared/gec_pkg.sv
// gesture engine configuration types
// assumes gec_defs.svh supplies the numbers
package gec_pkg;
   typedef struct packed {
      logic [7:0] north;
      logic [7:0] south;
      logic [7:0] west;
      logic [7:0] east;
   } gec_dataset_t;

   typedef enum logic [2:0] {
      GEC_IDLE,
      GEC_ADDR,
      GEC_PTR,
      GEC_WR,
      GEC_RD
   } gec_i2c_st_t;
endpackage

// file: hw/gec_top.sv
// gesture engine configuration, fifo and led pulse logic behind an i2c slave
// assumes scl/sda come from pins; samples and engine events share ref_clk
`include "gec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module gec_top (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe,
   input  wire logic                 sample_valid,
   input  wire gec_pkg::gec_dataset_t sample_data,
   input  wire logic                 cycle_start,
   input  wire logic                 entry_threshold,
   input  wire logic                 exit_threshold,
   input  wire logic                 conv_busy,
   output logic                      led_current_sink,
   output logic [2:0][7:0]           crosstalk_corr,
   output logic [1:0]                pair_enable,
   output logic                      double_rate,
   output logic                      gesture_run_flag,
   output logic                      gesture_irq_unmask,
   output logic                      queue_overflow_flag,
   output logic [7:0]                datasets_available
);
   // ----------------------------------------
   // pin synchronisers and bus events
   // ----------------------------------------
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
      end
   end
   logic scl_rise, scl_fall, bus_start, bus_stop, sda_b;
   assign sda_b     = sda_s_q[1];
   assign scl_rise  = scl_s_q[1] & ~scl_s_q[2];
   assign scl_fall  = ~scl_s_q[1] & scl_s_q[2];
   assign bus_start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
   assign bus_stop  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

   // ----------------------------------------
   // register and fifo state
   // ----------------------------------------
   logic [2:0][7:0]        offs_q;
   logic [7:0]             pulse_q;
   logic [1:0]             dims_q;
   logic                   unmask_q, run_q, exit_pend_q, ovf_q;
   logic [7:0]             level_q;
   logic [4:0]             wr_ptr_q, rd_ptr_q;
   gec_pkg::gec_dataset_t  fifo_q [32];
   gec_pkg::gec_i2c_st_t   st_q;
   logic [3:0]             cnt_q;
   logic [7:0]             sh_q, tx_q, ptr_q;
   logic                   ack_q, rw_q;
   logic                   reg_wr, rd_load, pop, push, full;
   logic [7:0]             rd_byte;

   assign full = (level_q == `GEC_FIFO_DEPTH);
   assign push = sample_valid & run_q;
   assign reg_wr = scl_fall & (st_q == gec_pkg::GEC_WR) & ~ack_q & (cnt_q == 4'h8);
   assign rd_load = scl_fall & ((st_q == gec_pkg::GEC_RD) & (cnt_q == 4'hA) |
                    (st_q == gec_pkg::GEC_ADDR) & ack_q & rw_q);
   assign pop = rd_load & (ptr_q == `GEC_FIFO_EAST) & (level_q != 8'h00);

   // read mux; zero past the last dataset
   always_comb begin
      rd_byte = 8'h00;
      if (ptr_q == `GEC_OFS_SOUTH) begin
         rd_byte = offs_q[0];
      end else if (ptr_q == `GEC_PULSE_SETUP) begin
         rd_byte = pulse_q;
      end else if (ptr_q == `GEC_OFS_WEST) begin
         rd_byte = offs_q[1];
      end else if (ptr_q == `GEC_OFS_EAST) begin
         rd_byte = offs_q[2];
      end else if (ptr_q == `GEC_PAIR_SEL) begin
         rd_byte = {6'h00, dims_q};
      end else if (ptr_q == `GEC_CONTROL) begin
         rd_byte = {6'h00, unmask_q, run_q};
      end else if (ptr_q == `GEC_QUEUE_LEVEL) begin
         rd_byte = level_q;
      end else if (level_q == 8'h00) begin
         rd_byte = 8'h00;
      end else if (ptr_q == `GEC_FIFO_NORTH) begin
         rd_byte = fifo_q[rd_ptr_q].north;
      end else if (ptr_q == `GEC_FIFO_SOUTH) begin
         rd_byte = fifo_q[rd_ptr_q].south;
      end else if (ptr_q == `GEC_FIFO_WEST) begin
         rd_byte = fifo_q[rd_ptr_q].west;
      end else if (ptr_q == `GEC_FIFO_EAST) begin
         rd_byte = fifo_q[rd_ptr_q].east;
      end
   end

   // ----------------------------------------
   // i2c slave
   // ----------------------------------------
   // page reads wrap inside the fifo window so a burst drains many datasets
   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      next_ptr = (p == `GEC_FIFO_EAST) ? `GEC_FIFO_NORTH : p + 8'h01;
   endfunction

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q   <= gec_pkg::GEC_IDLE;
         cnt_q  <= 4'h0;
         sh_q   <= 8'h00;
         tx_q   <= 8'h00;
         ptr_q  <= 8'h00;
         ack_q  <= 1'b0;
         rw_q   <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_start) begin
         st_q   <= gec_pkg::GEC_ADDR;
         cnt_q  <= 4'h0;
         ack_q  <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         st_q   <= gec_pkg::GEC_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         if (st_q == gec_pkg::GEC_RD) begin
            if (cnt_q == 4'h9) begin
               cnt_q <= 4'hA;
               if (sda_b) begin
                  st_q <= gec_pkg::GEC_IDLE;
               end
            end
         end else if (st_q != gec_pkg::GEC_IDLE && !ack_q) begin
            sh_q  <= {sh_q[6:0], sda_b};
            cnt_q <= cnt_q + 4'h1;
         end
      end else if (scl_fall) begin
         if (rd_load) begin
            st_q   <= gec_pkg::GEC_RD;
            ack_q  <= 1'b0;
            tx_q   <= rd_byte;
            sda_oe <= ~rd_byte[7];
            cnt_q  <= 4'h1;
            ptr_q  <= next_ptr(ptr_q);
         end else if (st_q == gec_pkg::GEC_RD) begin
            if (cnt_q < 4'h8) begin
               sda_oe <= ~tx_q[3'(4'h7 - cnt_q)];
               cnt_q  <= cnt_q + 4'h1;
            end else if (cnt_q == 4'h8) begin
               sda_oe <= 1'b0;
               cnt_q  <= 4'h9;
            end
         end else if (ack_q) begin
            ack_q  <= 1'b0;
            sda_oe <= 1'b0;
            cnt_q  <= 4'h0;
            if (st_q == gec_pkg::GEC_ADDR) begin
               st_q <= gec_pkg::GEC_PTR;
            end
         end else if (cnt_q == 4'h8) begin
            if (st_q == gec_pkg::GEC_ADDR) begin
               if (sh_q[7:1] == `GEC_DEV_ADDR) begin
                  ack_q  <= 1'b1;
                  sda_oe <= 1'b1;
                  rw_q   <= sh_q[0];
               end else begin
                  st_q <= gec_pkg::GEC_IDLE;
               end
            end else if (st_q == gec_pkg::GEC_PTR) begin
               ptr_q  <= sh_q;
               st_q   <= gec_pkg::GEC_WR;
               ack_q  <= 1'b1;
               sda_oe <= 1'b1;
            end else begin
               ptr_q  <= next_ptr(ptr_q);
               ack_q  <= 1'b1;
               sda_oe <= 1'b1;
            end
         end
      end
   end
   assign sda_out = 1'b0;

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         offs_q   <= {3{`GEC_RST_BYTE}};
         pulse_q  <= `GEC_RST_BYTE;
         dims_q   <= 2'h0;
         unmask_q <= 1'b0;
      end else if (reg_wr) begin
         if (ptr_q == `GEC_OFS_SOUTH) begin
            offs_q[0] <= sh_q;
         end else if (ptr_q == `GEC_PULSE_SETUP) begin
            pulse_q <= sh_q;
         end else if (ptr_q == `GEC_OFS_WEST) begin
            offs_q[1] <= sh_q;
         end else if (ptr_q == `GEC_OFS_EAST) begin
            offs_q[2] <= sh_q;
         end else if (ptr_q == `GEC_PAIR_SEL) begin
            dims_q <= sh_q[1:0]; // reserved bits dropped
         end else if (ptr_q == `GEC_CONTROL) begin
            unmask_q <= sh_q[`GEC_CTL_UNMASK];
         end
      end
   end

   // sign-magnitude to two's complement correction per channel
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_corr
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               crosstalk_corr[gi] <= 8'h00;
            end else if (offs_q[gi][`GEC_OFS_SIGN_BIT]) begin
               crosstalk_corr[gi] <= 8'h00 - {1'b0, offs_q[gi][6:0]};
            end else begin
               crosstalk_corr[gi] <= {1'b0, offs_q[gi][6:0]};
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pair_enable        <= 2'h3;
         double_rate        <= 1'b0;
         gesture_irq_unmask <= 1'b0;
      end else begin
         pair_enable        <= {dims_q != 2'h2, dims_q != 2'h1}; // {ns, we}
         double_rate        <= (dims_q == 2'h1) | (dims_q == 2'h2);
         gesture_irq_unmask <= unmask_q;
      end
   end

   // ----------------------------------------
   // gesture mode
   // ----------------------------------------
   logic ctl_wr;
   assign ctl_wr = reg_wr & (ptr_q == `GEC_CONTROL);
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_q       <= 1'b0;
         exit_pend_q <= 1'b0;
      end else if ((ctl_wr && sh_q[`GEC_CTL_RUN]) || entry_threshold) begin
         run_q       <= 1'b1;
         exit_pend_q <= 1'b0;
      end else if (exit_pend_q && !conv_busy) begin
         run_q       <= 1'b0;
         exit_pend_q <= 1'b0;
      end else if ((ctl_wr || exit_threshold) && run_q) begin
         exit_pend_q <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         gesture_run_flag <= 1'b0;
      end else begin
         gesture_run_flag <= run_q;
      end
   end

   // ----------------------------------------
   // dataset queue
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_ptr_q <= 5'h00;
         rd_ptr_q <= 5'h00;
         level_q  <= 8'h00;
         ovf_q    <= 1'b0;
      end else begin
         if (push && !full) begin
            fifo_q[wr_ptr_q] <= sample_data;
            wr_ptr_q         <= wr_ptr_q + 5'h01;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 5'h01;
         end
         if (push && !full && !pop) begin
            level_q <= level_q + 8'h01;
         end else if (pop && !(push && !full)) begin
            level_q <= level_q - 8'h01;
         end
         // full with a new arrival: drop it, keep the stored data
         if (push && full) begin
            ovf_q <= 1'b1;
         end else if (pop && level_q == 8'h01) begin
            ovf_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         queue_overflow_flag <= 1'b0;
         datasets_available  <= 8'h00;
      end else begin
         queue_overflow_flag <= ovf_q;
         datasets_available  <= level_q;
      end
   end

   // ----------------------------------------
   // led pulse train
   // ----------------------------------------
   logic [6:0] pulses_left_q;
   logic [8:0] width_cnt_q;
   logic [8:0] width;
   assign width = 9'(`GEC_PLEN_CYC) << pulse_q[7:6];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pulses_left_q    <= 7'h00;
         width_cnt_q      <= 9'h000;
         led_current_sink <= 1'b0;
      end else if (pulses_left_q == 7'h00) begin
         led_current_sink <= 1'b0;
         if (cycle_start && run_q) begin
            pulses_left_q <= {1'b0, pulse_q[5:0]} + 7'h01;
            // preloaded so the first pulse opens on the next edge
            width_cnt_q   <= width - 9'h001;
         end
      end else if (width_cnt_q == width - 9'h001) begin
         width_cnt_q      <= 9'h000;
         led_current_sink <= ~led_current_sink;
         if (led_current_sink) begin
            pulses_left_q <= pulses_left_q - 7'h01;
         end
      end else begin
         // high and low phases both last the full width
         width_cnt_q <= width_cnt_q + 9'h001;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [8:0] hi_cnt_q;
   logic [6:0] n_pulse_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !led_current_sink) begin
         hi_cnt_q <= 9'h000;
      end else begin
         hi_cnt_q <= hi_cnt_q + 9'h001;
      end
      if (!rst_n || (cycle_start && pulses_left_q == 7'h00)) begin
         n_pulse_q <= 7'h00;
      end else if (led_current_sink && hi_cnt_q == 9'h000) begin
         n_pulse_q <= n_pulse_q + 7'h01;
      end
   end

   property p_width;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(led_current_sink) |-> $past(hi_cnt_q) == width - 9'h001;
   endproperty
   a_width: assert property (p_width) else $error("led width wrong");
   property p_count;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(pulses_left_q != 7'h00) |-> n_pulse_q == {1'b0, pulse_q[5:0]} + 7'h01;
   endproperty
   a_count: assert property (p_count) else $error("pulse count wrong");
   property p_sign;
      @(posedge ref_clk) disable iff (!rst_n)
      ##1 $past(offs_q[2][7]) && $past(offs_q[2][6:0]) != 7'h00 |-> crosstalk_corr[2][7];
   endproperty
   a_sign: assert property (p_sign) else $error("sign lost");
   property p_enter;
      @(posedge ref_clk) disable iff (!rst_n)
      ctl_wr && sh_q[0] |=> run_q ##1 gesture_run_flag;
   endproperty
   a_enter: assert property (p_enter) else $error("no entry");
   property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      run_q && exit_pend_q && conv_busy && !entry_threshold |=> run_q;
   endproperty
   a_hold: assert property (p_hold) else $error("early exit");
   property p_ovf;
      @(posedge ref_clk) disable iff (!rst_n)
      push && full && !pop |=> ovf_q && level_q == `GEC_FIFO_DEPTH;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow wrong");
   property p_pop;
      @(posedge ref_clk) disable iff (!rst_n)
      pop && !push |=> level_q == $past(level_q) - 8'h01 && rd_ptr_q == $past(rd_ptr_q) + 5'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop mismatch");
   property p_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      rd_load && level_q == 8'h00 && ptr_q[7:2] == 6'h3F |=> tx_q == 8'h00;
   endproperty
   a_zero: assert property (p_zero) else $error("empty read nonzero");
   property p_unmask;
      @(posedge ref_clk) disable iff (!rst_n)
      ctl_wr |=> ##1 gesture_irq_unmask == $past(sh_q[1], 2);
   endproperty
   a_unmask: assert property (p_unmask) else $error("unmask wrong");
   c_ovf: cover property (@(posedge ref_clk) disable iff (!rst_n) push && full);
   c_pop: cover property (@(posedge ref_clk) disable iff (!rst_n) pop);
   c_burst: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(pulses_left_q != 7'h00));
endmodule
`default_nettype wire

// file: verification/gec_host.sv
// host model: i2c master that bit-bangs scl and sda, one bit per 800 ns
// assumes the bench wires sda open-drain with a pull-up and feeds the level back
`include "gec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module gec_host (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output var logic  scl,
   output var logic  sda_m
);
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   logic [7:0] rd_buf [0:127];
   int         nacks;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
      nacks = 0;
   end
   // quarter bit; scl stands still between frames
   task automatic q();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic bit_x(input logic b, output logic r);
      q();
      sda_m = b;
      q();
      scl = 1'b1;
      q();
      r = sda_line;
      q();
      scl = 1'b0;
   endtask
   task automatic start();
      q();
      sda_m = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_m = 1'b0;
      q();
      scl = 1'b0;
   endtask
   task automatic stop();
      q();
      sda_m = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_m = 1'b1;
      q();
   endtask
   task automatic wb(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      if (r !== 1'b0) nacks++;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      if (ptr == `GEC_PAIR_SEL || ptr == `GEC_CONTROL) d = d & 8'h03;
      start();
      wb({`GEC_DEV_ADDR, 1'b0});
      wb(ptr);
      wb(d);
      stop();
   endtask
   // page read; last byte gets a nack to end the transfer
   task automatic rd(input logic [7:0] ptr, input int n);
      logic r;
      start();
      wb({`GEC_DEV_ADDR, 1'b0});
      wb(ptr);
      start();
      wb({`GEC_DEV_ADDR, 1'b1});
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) bit_x(1'b1, rd_buf[k][i]);
         bit_x(k == n - 1, r);
      end
      stop();
   endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the gesture configuration block
// assumes gec_host as i2c partner; converter and engine events driven here
`include "gec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ----------------------------------------
   // wiring and helpers
   // ----------------------------------------
   logic                  ref_clk, rst_n, sample_valid, cycle_start;
   logic                  entry_threshold, exit_threshold, conv_busy;
   logic                  sda_out, sda_oe, led_current_sink, double_rate;
   logic                  gesture_run_flag, gesture_irq_unmask, queue_overflow_flag;
   logic                  scl, sda_m;
   logic [2:0][7:0]       crosstalk_corr;
   logic [1:0]            pair_enable;
   logic [7:0]            datasets_available;
   gec_pkg::gec_dataset_t sample_data;
   int                    num_errors, samples_checked;
   wire                   sda_line = sda_m & ~sda_oe;
   gec_host gec_host_i (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
   gec_top gec_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .sample_valid(sample_valid),
      .sample_data(sample_data), .cycle_start(cycle_start),
      .entry_threshold(entry_threshold), .exit_threshold(exit_threshold),
      .conv_busy(conv_busy), .led_current_sink(led_current_sink),
      .crosstalk_corr(crosstalk_corr), .pair_enable(pair_enable),
      .double_rate(double_rate), .gesture_run_flag(gesture_run_flag),
      .gesture_irq_unmask(gesture_irq_unmask),
      .queue_overflow_flag(queue_overflow_flag),
      .datasets_available(datasets_available));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   function automatic logic [7:0] byt(input int idx, input int k);
      return 8'(idx + 1 + k * 64);
   endfunction
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      gec_host_i.rd(a, 1);
      check(gec_host_i.rd_buf[0], e);
   endtask
   task automatic pulse_entry();
      entry_threshold = 1'b1;
      tick(1);
      entry_threshold = 1'b0;
      tick(3);
   endtask
   // back-to-back pushes, one dataset per cycle
   task automatic push(input int n, input int b);
      for (int i = b; i < b + n; i++) begin
         sample_valid = 1'b1;
         sample_data = {byt(i, 0), byt(i, 1), byt(i, 2), byt(i, 3)};
         tick(1);
      end
      sample_valid = 1'b0;
      tick(3);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [7:0] regs [7] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'hAE};
      check({gesture_run_flag, gesture_irq_unmask, queue_overflow_flag, sda_out, sda_oe}, 0);
      check(pair_enable, 2'b11);
      foreach (regs[i]) rdc(regs[i], 8'h00);
   endtask
   task automatic t_offsets();
      gec_host_i.wr(`GEC_OFS_SOUTH, 8'h82);
      gec_host_i.wr(`GEC_OFS_WEST, 8'hFF);
      gec_host_i.wr(`GEC_OFS_EAST, 8'h05);
      gec_host_i.wr(8'hA8, 8'h5A);
      check(crosstalk_corr[0], 8'hFE);
      check(crosstalk_corr[1], 8'h81);
      check(crosstalk_corr[2], 8'h05);
      rdc(`GEC_OFS_WEST, 8'hFF);
      rdc(8'hA8, 8'h00);
   endtask
   task automatic t_pairs();
      logic [1:0] en [4] = '{2'b11, 2'b10, 2'b01, 2'b11};
      for (int c = 0; c < 4; c++) begin
         gec_host_i.wr(`GEC_PAIR_SEL, 8'(c));
         check(pair_enable, en[c]);
         check(double_rate, c == 1 || c == 2);
         rdc(`GEC_PAIR_SEL, 8'(c));
      end
   endtask
   task automatic t_mode();
      gec_host_i.wr(`GEC_CONTROL, 8'h02);
      check({gesture_irq_unmask, gesture_run_flag}, 2'b10);
      conv_busy = 1'b1;
      gec_host_i.wr(`GEC_CONTROL, 8'h03);
      check(gesture_run_flag, 1'b1);
      rdc(`GEC_CONTROL, 8'h03);
      gec_host_i.wr(`GEC_CONTROL, 8'h02);
      tick(8);
      check(gesture_run_flag, 1'b1);
      conv_busy = 1'b0;
      tick(4);
      check(gesture_run_flag, 1'b0);
      rdc(`GEC_CONTROL, 8'h02);
      pulse_entry();
      check(gesture_run_flag, 1'b1);
      exit_threshold = 1'b1;
      tick(1);
      exit_threshold = 1'b0;
      tick(4);
      check(gesture_run_flag, 1'b0);
      gec_host_i.wr(`GEC_CONTROL, 8'h00);
      check(gesture_irq_unmask, 1'b0);
   endtask
   task automatic t_fifo();
      pulse_entry();
      push(2, 0);
      check(datasets_available, 8'h02);
      rdc(`GEC_QUEUE_LEVEL, 8'h02);
      gec_host_i.rd(`GEC_FIFO_NORTH, 3);
      for (int k = 0; k < 3; k++) check(gec_host_i.rd_buf[k], byt(0, k));
      check(datasets_available, 8'h02);
      rdc(`GEC_FIFO_EAST, byt(0, 3));
      check(datasets_available, 8'h01);
      gec_host_i.rd(`GEC_FIFO_NORTH, 8);
      for (int k = 0; k < 4; k++) check(gec_host_i.rd_buf[k], byt(1, k));
      for (int k = 4; k < 8; k++) check(gec_host_i.rd_buf[k], 8'h00);
      check(datasets_available, 8'h00);
      push(33, 2);
      check(datasets_available, 8'h20);
      check(queue_overflow_flag, 1'b1);
      gec_host_i.rd(`GEC_FIFO_NORTH, 128);
      for (int j = 0; j < 128; j++) check(gec_host_i.rd_buf[j], byt(j / 4 + 2, j % 4));
      check({queue_overflow_flag, datasets_available}, 9'h000);
      // north-south only: west and east bytes are not valid, so skip them
      gec_host_i.wr(`GEC_PAIR_SEL, 8'h01);
      push(1, 40);
      gec_host_i.rd(`GEC_FIFO_NORTH, 4);
      for (int k = 0; k < 2; k++) check(gec_host_i.rd_buf[k], byt(40, k));
      check(datasets_available, 8'h00);
      gec_host_i.wr(`GEC_PAIR_SEL, 8'h00);
   endtask
   task automatic t_led();
      int hi, edges;
      logic prev;
      for (int c = 0; c < 4; c++) begin
         gec_host_i.wr(`GEC_PULSE_SETUP, {2'(c), 6'(c)});
         rdc(`GEC_PULSE_SETUP, {2'(c), 6'(c)});
         cycle_start = 1'b1;
         tick(1);
         cycle_start = 1'b0;
         hi = 0;
         edges = 0;
         prev = 1'b0;
         for (int n = 0; n < 2600; n++) begin
            tick(1);
            hi += (led_current_sink === 1'b1);
            edges += (led_current_sink === 1'b1 && !prev);
            prev = (led_current_sink === 1'b1);
         end
         check(edges, c + 1);
         check(hi, (c + 1) * (`GEC_PLEN_CYC << c));
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      num_errors = 0;
      samples_checked = 0;
      {rst_n, sample_valid, cycle_start, entry_threshold, exit_threshold, conv_busy} = 0;
      sample_data = '0;
      repeat (5) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      tick(3);
      t_reset();
      t_offsets();
      t_pairs();
      t_mode();
      t_fifo();
      t_led();
      check(gec_host_i.nacks, 0);
      summarize();
   end
endmodule
`default_nettype wire
